// file: src/fpu_pkg.sv
package fpu_pkg;
	// Register file addresses (12-bit register space)
	localparam logic [11:0] FPU_ADDR_CMD    = 12'hFF8;
	localparam logic [11:0] FPU_ADDR_PAGE   = 12'hFF9;
	localparam logic [11:0] FPU_ADDR_FRQ_HI = 12'hFFA;
	localparam logic [11:0] FPU_ADDR_FRQ_LO = 12'hFFB;
	// Command codes
	localparam logic [7:0]  FPU_CMD_UNLOCK1 = 8'h73;
	localparam logic [7:0]  FPU_CMD_UNLOCK2 = 8'h8C;
	localparam logic [7:0]  FPU_CMD_PERASE  = 8'h95;
	localparam logic [7:0]  FPU_CMD_MERASE  = 8'h63;
	localparam logic [7:0]  FPU_CMD_SECTOR  = 8'h5E;
	// Geometry
	localparam int          FPU_PAGE_BYTES  = 512;
	localparam int          FPU_ROW_BYTES   = 64;
	localparam int          FPU_ROWS        = 8;
	localparam int          FPU_SECT_BIG    = 1024;
	localparam int          FPU_SECT_SMALL  = 512;
	localparam int          FPU_SECTORS     = 8;
	localparam int          FPU_OPT_BYTES   = 2;
	localparam logic [15:0] FPU_INFO_LO     = 16'hFE00;
	localparam logic [15:0] FPU_INFO_HI     = 16'hFFFF;
	// Reset values
	localparam logic [7:0]  FPU_SECT_RST    = 8'h00;
	localparam logic [15:0] FPU_FRQ_RST     = 16'h0000;
	localparam logic [7:0]  FPU_PAGE_RST    = 8'h00;
	// Operation times in microseconds, scaled by the kHz value
	localparam int          FPU_T_PROG_US   = 40;
	localparam int          FPU_T_ERASE_US  = 10000;
	localparam logic [7:0]  FPU_US_PER_MS   = 8'd1;
	// Status codes
	localparam logic [5:0]  FPU_ST_LOCKED   = 6'h00;
	localparam logic [5:0]  FPU_ST_ARM1     = 6'h01;
	localparam logic [5:0]  FPU_ST_ARM2     = 6'h02;
	localparam logic [5:0]  FPU_ST_OPEN     = 6'h03;
	localparam logic [5:0]  FPU_ST_SECT     = 6'h04;
	localparam logic [5:0]  FPU_ST_PROG     = 6'h08;
	localparam logic [5:0]  FPU_ST_PERASE   = 6'h18;
	localparam logic [5:0]  FPU_ST_MERASE   = 6'h38;

	typedef enum logic [2:0] {
		FPU_LOCKED = 3'b000,
		FPU_ARM1   = 3'b001,
		FPU_ARM2   = 3'b011,
		FPU_OPEN   = 3'b010,
		FPU_BUSY   = 3'b110
	} fpu_state_t;

	typedef enum logic [1:0] {
		FPU_OP_PROG   = 2'b00,
		FPU_OP_PERASE = 2'b01,
		FPU_OP_MERASE = 2'b10
	} fpu_op_t;

	// Page number holding a byte address
	function automatic logic [3:0] fpu_page_of(input logic [12:0] a);
		return a[12:9];
	endfunction

	// Sector index for a page: 1 KB sectors on 8 KB, page-sized otherwise
	function automatic logic [2:0] fpu_sector_of(input logic [3:0] pg, input logic big);
		return big ? pg[3:1] : pg[2:0];
	endfunction
endpackage

// file: src/fpu_timer.sv
`timescale 1ns/10ps
module fpu_timer
	import fpu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic        long_op,
	input  wire logic [15:0] khz,
	output logic             done
);
	// One microsecond tick from khz/1000 cycles, then count microseconds
	logic [15:0] div_q;
	logic [13:0] us_q;
	logic        run_q;
	logic [15:0] khz_div;
	logic [15:0] cyc_per_us;
	logic        tick;
	logic [13:0] us_goal;

	assign khz_div    = khz / 16'h03E8;
	assign cyc_per_us = (khz_div == 16'h0000) ? 16'h0001 : khz_div;
	assign tick       = run_q && (div_q + 16'd1 >= cyc_per_us);
	assign us_goal    = long_op ? 14'(FPU_T_ERASE_US) : 14'(FPU_T_PROG_US);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 16'h0000;
			us_q  <= 14'h0000;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				run_q <= 1'b1;
				div_q <= 16'h0000;
				us_q  <= 14'h0000;
			end else if (tick) begin
				div_q <= 16'h0000;
				us_q  <= us_q + 14'h0001;
				if (us_q + 14'h0001 >= us_goal) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end
			end else if (run_q) begin
				div_q <= div_q + 16'h0001;
			end
		end
	end
endmodule

// file: src/fpu_ctrl.sv
// Function
// - 512-byte pages of eight 64-byte rows
// - Sectors 1024 bytes on 8KB, else 512
// - At most eight sectors, never below page
// - First two bytes hold option bits
// - Information area readable, never erased or programmed
// - High and low bytes form kHz value
// - Read protect hides code from debugger
// - Write protect zero blocks user operations
// - Write protect one permits operations
// - Reset enters locked state
// - Page mismatch locks, match activates page
// - 95H erases active unprotected page
// - Other command while unlocked relocks
// - Mass erase only from debug port
// - Byte writes keep page open until command
// - 5EH maps sector register at page address
// - Sector bits reset zero, user sets only
// - Sector bits block CPU, not debugger
// - Command write and status read share FF8H
// - Programming only clears bits
// - Page erase completion relocks
`timescale 1ns/10ps
module fpu_ctrl
	import fpu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        size_8k,
	input  wire logic        read_protect_option,
	input  wire logic        write_protect_option,
	input  wire logic        dbg_mode,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic [7:0]  mem_rdata_in,
	output logic      [7:0]  mem_rdata,
	output logic             cpu_stall,
	output logic             fl_prog,
	output logic             fl_page_erase,
	output logic             fl_mass_erase,
	output logic      [12:0] fl_addr,
	output logic      [7:0]  fl_wdata
);
	fpu_state_t  state_q;
	fpu_op_t     op_q;
	logic [7:0]  page_q;
	logic [7:0]  page1_q;
	logic [7:0]  sect_q;
	logic        sect_sel_q;
	logic [7:0]  frq_hi_q;
	logic [7:0]  frq_lo_q;
	logic        tmr_start_q;
	logic        tmr_done;

	logic        wr_cmd;
	logic        wr_page;
	logic        wr_fhi;
	logic        wr_flo;
	logic [15:0] khz;
	logic [3:0]  act_page;
	logic [2:0]  act_sect;
	logic        sect_locked;
	logic        user_wp_ok;
	logic        in_info;
	logic        in_opt;
	logic        wr_hit;
	logic        prog_ok;
	logic        perase_ok;
	logic        merase_ok;
	logic [5:0]  stat_code;
	logic [7:0]  rd_mux;
	logic [7:0]  mem_mux;
	logic [7:0]  sect_next;
	logic        mem_page_ok;

	assign wr_cmd  = reg_wr && (reg_addr == FPU_ADDR_CMD);
	assign wr_page = reg_wr && (reg_addr == FPU_ADDR_PAGE);
	assign wr_fhi  = reg_wr && (reg_addr == FPU_ADDR_FRQ_HI);
	assign wr_flo  = reg_wr && (reg_addr == FPU_ADDR_FRQ_LO);

	assign khz = {frq_hi_q, frq_lo_q};

	// Page and sector geometry
	assign act_page    = page_q[3:0];
	assign act_sect    = fpu_sector_of(act_page, size_8k);
	assign sect_locked = sect_q[act_sect] && !dbg_mode;

	assign user_wp_ok = write_protect_option || dbg_mode;
	assign in_info    = (mem_addr >= FPU_INFO_LO);
	assign in_opt     = (mem_addr < 16'(FPU_OPT_BYTES));
	assign wr_hit     = mem_wr && !in_info;
	assign mem_page_ok = dbg_mode || (fpu_page_of(mem_addr[12:0]) == act_page);

	assign prog_ok = (state_q == FPU_OPEN) && wr_hit && user_wp_ok && !sect_locked
		&& mem_page_ok;
	assign perase_ok = (state_q == FPU_OPEN) && wr_cmd && (reg_wdata == FPU_CMD_PERASE)
		&& user_wp_ok && !sect_locked;
	assign merase_ok = (state_q == FPU_OPEN) && wr_cmd && (reg_wdata == FPU_CMD_MERASE)
		&& dbg_mode;

	// User code may only set sector bits; debugger writes freely
	assign sect_next = dbg_mode ? reg_wdata : (sect_q | reg_wdata);

	assign stat_code = (state_q == FPU_BUSY) ?
		((op_q == FPU_OP_PROG) ? FPU_ST_PROG :
		 (op_q == FPU_OP_PERASE) ? FPU_ST_PERASE : FPU_ST_MERASE) :
		(state_q == FPU_ARM1) ? FPU_ST_ARM1 :
		(state_q == FPU_ARM2) ? FPU_ST_ARM2 :
		(state_q == FPU_OPEN) ? FPU_ST_OPEN :
		sect_sel_q ? FPU_ST_SECT : FPU_ST_LOCKED;

	assign rd_mux = (reg_addr == FPU_ADDR_CMD) ? {2'b00, stat_code} :
		(reg_addr == FPU_ADDR_PAGE) ? (sect_sel_q ? sect_q : page_q) :
		(reg_addr == FPU_ADDR_FRQ_HI) ? frq_hi_q :
		(reg_addr == FPU_ADDR_FRQ_LO) ? frq_lo_q : 8'h00;

	// Debugger reads of user code blocked when read protected; option bytes stay visible
	assign mem_mux = (dbg_mode && read_protect_option && !in_info && !in_opt) ? 8'h00
		: mem_rdata_in;

	fpu_timer u_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (tmr_start_q),
		.long_op (op_q != FPU_OP_PROG),
		.khz     (khz),
		.done    (tmr_done)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			frq_hi_q <= FPU_FRQ_RST[15:8];
			frq_lo_q <= FPU_FRQ_RST[7:0];
		end else begin
			if (wr_fhi)
				frq_hi_q <= reg_wdata;
			if (wr_flo)
				frq_lo_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sect_q     <= FPU_SECT_RST;
			sect_sel_q <= 1'b0;
		end else begin
			if (wr_cmd)
				sect_sel_q <= (reg_wdata == FPU_CMD_SECTOR);
			if (wr_page && sect_sel_q)
				sect_q <= sect_next;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q     <= FPU_LOCKED;
			op_q        <= FPU_OP_PROG;
			page_q      <= FPU_PAGE_RST;
			page1_q     <= FPU_PAGE_RST;
			tmr_start_q <= 1'b0;
			cpu_stall   <= 1'b0;
			fl_prog     <= 1'b0;
			fl_page_erase <= 1'b0;
			fl_mass_erase <= 1'b0;
			fl_addr     <= 13'h0000;
			fl_wdata    <= 8'hFF;
		end else begin
			tmr_start_q <= 1'b0;
			if (wr_page && !sect_sel_q && (state_q != FPU_BUSY) &&
			    (state_q != FPU_OPEN || dbg_mode))
				page_q <= reg_wdata;
			unique case (state_q)
				FPU_LOCKED: begin
					if (wr_cmd && reg_wdata == FPU_CMD_UNLOCK1) begin
						state_q <= FPU_ARM1;
						page1_q <= page_q;
					end
				end
				FPU_ARM1: begin
					if (wr_cmd)
						state_q <= (reg_wdata == FPU_CMD_UNLOCK2) ? FPU_ARM2 : FPU_LOCKED;
				end
				FPU_ARM2: begin
					if (wr_cmd)
						state_q <= FPU_LOCKED;
					else if (wr_page)
						state_q <= (reg_wdata == page1_q) ? FPU_OPEN
							: FPU_LOCKED;
					else if (dbg_mode)
						state_q <= FPU_OPEN;
				end
				FPU_OPEN: begin
					if (perase_ok) begin
						state_q       <= FPU_BUSY;
						op_q          <= FPU_OP_PERASE;
						fl_page_erase <= 1'b1;
						fl_addr       <= {act_page, 9'h000};
						tmr_start_q   <= 1'b1;
						cpu_stall     <= !dbg_mode;
					end else if (merase_ok) begin
						state_q       <= FPU_BUSY;
						op_q          <= FPU_OP_MERASE;
						fl_mass_erase <= 1'b1;
						tmr_start_q   <= 1'b1;
					end else if (wr_cmd) begin
						state_q <= FPU_LOCKED;
					end else if (prog_ok) begin
						state_q     <= FPU_BUSY;
						op_q        <= FPU_OP_PROG;
						fl_prog     <= 1'b1;
						fl_addr     <= mem_addr[12:0];
						fl_wdata    <= mem_wdata & mem_rdata_in;
						tmr_start_q <= 1'b1;
						cpu_stall   <= !dbg_mode;
					end
				end
				FPU_BUSY: begin
					if (tmr_done) begin
						fl_prog       <= 1'b0;
						fl_page_erase <= 1'b0;
						fl_mass_erase <= 1'b0;
						cpu_stall     <= 1'b0;
						// Erase relocks; byte program keeps the page open
						state_q <= (op_q == FPU_OP_PROG) ? FPU_OPEN : FPU_LOCKED;
					end
				end
				default: state_q <= FPU_LOCKED;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			mem_rdata <= 8'h00;
		end else begin
			if (reg_rd)
				reg_rdata <= rd_mux;
			if (mem_rd)
				mem_rdata <= mem_mux;
		end
	end

	property p_reset_locked;
		@(posedge clk) $fell(sys_rst) |-> state_q == FPU_LOCKED;
	endproperty
	a_reset_locked: assert property (p_reset_locked) else $error("not locked after reset");

	property p_mismatch;
		@(posedge clk) disable iff (sys_rst)
		(state_q == FPU_ARM2 && wr_page && !wr_cmd && reg_wdata != page1_q)
			|=> state_q == FPU_LOCKED;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("page mismatch did not relock");

	property p_open_other;
		@(posedge clk) disable iff (sys_rst)
		(state_q == FPU_OPEN && wr_cmd && reg_wdata != FPU_CMD_PERASE &&
		 reg_wdata != FPU_CMD_MERASE) |=> state_q == FPU_LOCKED;
	endproperty
	a_open_other: assert property (p_open_other) else $error("stray command kept unlocked");

	property p_user_no_mass;
		@(posedge clk) disable iff (sys_rst)
		!dbg_mode |-> ##1 !$rose(fl_mass_erase);
	endproperty
	a_user_no_mass: assert property (p_user_no_mass) else $error("user mass erase");

	property p_wp_block;
		@(posedge clk) disable iff (sys_rst)
		(!write_protect_option && !dbg_mode) |=> !$rose(fl_prog) && !$rose(fl_page_erase);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("write protect ignored");

	property p_sect_sticky;
		@(posedge clk) disable iff (sys_rst)
		!dbg_mode |=> (($past(sect_q) & ~sect_q) == 8'h00);
	endproperty
	a_sect_sticky: assert property (p_sect_sticky) else $error("sector bit cleared");

	property p_sect_erase;
		@(posedge clk) disable iff (sys_rst)
		(state_q == FPU_OPEN && wr_cmd && reg_wdata == FPU_CMD_PERASE && sect_locked)
			|=> !fl_page_erase;
	endproperty
	a_sect_erase: assert property (p_sect_erase) else $error("protected sector erased");

	sequence s_erase_run;
		fl_page_erase && state_q == FPU_BUSY;
	endsequence
	property p_erase_relock;
		@(posedge clk) disable iff (sys_rst)
		s_erase_run ##0 tmr_done |=> state_q == FPU_LOCKED && !fl_page_erase;
	endproperty
	a_erase_relock: assert property (p_erase_relock) else $error("erase did not relock");

	property p_prog_clears;
		@(posedge clk) disable iff (sys_rst)
		$rose(fl_prog) |-> ((fl_wdata & ~$past(mem_rdata_in)) == 8'h00);
	endproperty
	a_prog_clears: assert property (p_prog_clears) else $error("program set a bit");

	property p_info_safe;
		@(posedge clk) disable iff (sys_rst)
		(mem_wr && in_info) |=> !$rose(fl_prog);
	endproperty
	a_info_safe: assert property (p_info_safe) else $error("info area written");

	sequence s_second_page;
		state_q == FPU_ARM2 && wr_page && !wr_cmd;
	endsequence
	property p_match_open;
		@(posedge clk) disable iff (sys_rst)
		s_second_page ##0 (reg_wdata == page1_q) |=> state_q == FPU_OPEN;
	endproperty
	a_match_open: assert property (p_match_open) else $error("match not opened");

	property p_prog_stays_open;
		@(posedge clk) disable iff (sys_rst)
		(state_q == FPU_BUSY && op_q == FPU_OP_PROG && tmr_done) |=> state_q == FPU_OPEN;
	endproperty
	a_prog_stays_open: assert property (p_prog_stays_open) else $error("page closed");

	property p_sect_select;
		@(posedge clk) disable iff (sys_rst)
		wr_cmd |=> sect_sel_q == ($past(reg_wdata) == FPU_CMD_SECTOR);
	endproperty
	a_sect_select: assert property (p_sect_select) else $error("guard select wrong");

	property p_sect_prog;
		@(posedge clk) disable iff (sys_rst)
		(mem_wr && sect_locked) |=> !$rose(fl_prog);
	endproperty
	a_sect_prog: assert property (p_sect_prog) else $error("guarded sector programmed");
endmodule

// file: bench/fpu_flash_model.sv
`timescale 1ns/10ps
module fpu_flash_model
	import fpu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic        fl_prog,
	input  wire logic        fl_page_erase,
	input  wire logic        fl_mass_erase,
	input  wire logic [12:0] fl_addr,
	input  wire logic [7:0]  fl_wdata,
	output logic      [7:0]  mem_rdata_in
);
	logic [7:0] arr_q [0:8191];
	logic       prog_q;
	logic       pe_q;
	logic       me_q;

	initial begin
		for (int i = 0; i < 8192; i++) begin
			arr_q[i] = i[7:0] ^ 8'h5A;
		end
	end

	// Information area always reads a fixed trim byte
	assign mem_rdata_in = (mem_addr >= FPU_INFO_LO) ? 8'hC3 : arr_q[mem_addr[12:0]];

	always @(posedge clk) begin
		prog_q <= fl_prog;
		pe_q <= fl_page_erase;
		me_q <= fl_mass_erase;
		// Cells only lose charge when programmed
		if (fl_prog && !prog_q) begin
			arr_q[fl_addr] <= arr_q[fl_addr] & fl_wdata;
		end
		// Erase restores a whole 512-byte page to FF
		if (fl_page_erase && !pe_q) begin
			for (int i = 0; i < 512; i++) begin
				arr_q[{fl_addr[12:9], i[8:0]}] <= 8'hFF;
			end
		end
		if (fl_mass_erase && !me_q) begin
			for (int i = 0; i < 8192; i++) begin
				arr_q[i] <= 8'hFF;
			end
		end
	end
endmodule

// file: bench/test_flash_protect_unlock_ctrl.sv
`timescale 1ns/10ps
module test_flash_protect_unlock_ctrl
	import fpu_pkg::*;
;
	logic        clk, sys_rst, size_8k, dbg_mode;
	logic        read_protect_option, write_protect_option;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, rd_q;
	logic        reg_wr, reg_rd, mem_wr, mem_rd;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata_in, mem_rdata, fl_wdata;
	logic        cpu_stall, fl_prog, fl_page_erase, fl_mass_erase;
	logic [12:0] fl_addr;
	int          err_count, check_count;

	fpu_ctrl i_fpu_ctrl (.clk(clk), .sys_rst(sys_rst), .size_8k(size_8k),
		.read_protect_option(read_protect_option), .write_protect_option(write_protect_option),
		.dbg_mode(dbg_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata_in(mem_rdata_in), .mem_rdata(mem_rdata),
		.cpu_stall(cpu_stall), .fl_prog(fl_prog), .fl_page_erase(fl_page_erase),
		.fl_mass_erase(fl_mass_erase), .fl_addr(fl_addr), .fl_wdata(fl_wdata));
	fpu_flash_model i_fpu_flash_model (.clk(clk), .mem_addr(mem_addr), .fl_prog(fl_prog),
		.fl_page_erase(fl_page_erase), .fl_mass_erase(fl_mass_erase), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .mem_rdata_in(mem_rdata_in));

	function automatic logic [7:0] pat(input logic [12:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction

	task automatic report_and_stop();
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		rd_q = reg_rdata;
	endtask

	task automatic mwr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		mem_addr <= a;
		mem_wdata <= d;
		mem_wr <= 1'b1;
		@(posedge clk);
		mem_wr <= 1'b0;
	endtask

	task automatic mrd(input logic [15:0] a);
		@(posedge clk);
		mem_addr <= a;
		mem_rd <= 1'b1;
		@(posedge clk);
		mem_rd <= 1'b0;
		@(posedge clk);
		rd_q = mem_rdata;
	endtask

	// Command write, then look at the operation outputs one edge later
	task automatic cmd(input logic [7:0] c);
		wr(FPU_ADDR_CMD, c);
		@(posedge clk);
		#1;
	endtask

	task automatic unlock(input logic [7:0] pg);
		wr(FPU_ADDR_PAGE, pg);
		wr(FPU_ADDR_CMD, FPU_CMD_UNLOCK1);
		wr(FPU_ADDR_CMD, FPU_CMD_UNLOCK2);
		if (dbg_mode !== 1'b1) begin
			wr(FPU_ADDR_PAGE, pg);
		end
	endtask

	task automatic wait_idle(output int n);
		n = 0;
		while ((fl_prog | fl_page_erase | fl_mass_erase | cpu_stall) !== 1'b0) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 30000) begin
				err_count++;
				$display("BAD %0t operation hangs", $time);
				report_and_stop();
			end
		end
	endtask

	task automatic t_reset();
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_LOCKED, "status after reset");
		wr(FPU_ADDR_CMD, 8'h00);
		wr(FPU_ADDR_CMD, FPU_CMD_SECTOR);
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_SECT, "guard not selected");
		rd(FPU_ADDR_PAGE);
		chk(rd_q, FPU_SECT_RST, "guard after reset");
		wr(FPU_ADDR_CMD, 8'h00);
	endtask

	task automatic t_erase();
		int n;
		unlock(8'h02);
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_OPEN, "not unlocked");
		cmd(FPU_CMD_PERASE);
		chk({cpu_stall, fl_page_erase, fl_addr[12:9]}, 6'h32, "erase start");
		wait_idle(n);
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_LOCKED, "not relocked");
		mrd(16'h0433);
		chk(rd_q, 8'hFF, "page not blank");
		mrd(16'h0633);
		chk(rd_q, pat(13'h0633), "neighbour erased");
	endtask

	task automatic t_mismatch();
		wr(FPU_ADDR_PAGE, 8'h02);
		wr(FPU_ADDR_CMD, FPU_CMD_UNLOCK1);
		wr(FPU_ADDR_CMD, FPU_CMD_UNLOCK2);
		wr(FPU_ADDR_PAGE, 8'h03);
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_LOCKED, "mismatch unlocked");
		cmd(FPU_CMD_PERASE);
		chk(fl_page_erase, 1'b0, "locked erase");
	endtask

	task automatic t_prog(input logic [15:0] khz, input logic [7:0] d, input logic [7:0] old);
		int n;
		int t;
		t = FPU_T_PROG_US * khz / 1000;
		wr(FPU_ADDR_FRQ_HI, khz[15:8]);
		wr(FPU_ADDR_FRQ_LO, khz[7:0]);
		unlock(8'h03);
		mwr(16'h0605, d);
		@(posedge clk);
		#1;
		chk({cpu_stall, fl_prog, fl_wdata}, {2'b11, d & old}, "program start");
		wait_idle(n);
		chk(n >= t - 3 && n <= t + 2, 1'b1, "program time");
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_OPEN, "closed after write");
		wr(FPU_ADDR_CMD, 8'h00);
		rd(FPU_ADDR_CMD);
		chk(rd_q, FPU_ST_LOCKED, "open after command");
		mrd(16'h0605);
		chk(rd_q, d & old, "readback");
	endtask

	task automatic t_guard();
		int n;
		wr(FPU_ADDR_CMD, 8'h00);
		wr(FPU_ADDR_CMD, FPU_CMD_SECTOR);
		wr(FPU_ADDR_PAGE, 8'h01);
		wr(FPU_ADDR_PAGE, 8'h00);
		rd(FPU_ADDR_PAGE);
		chk(rd_q, 8'h01, "guard bit cleared");
		wr(FPU_ADDR_CMD, 8'h00);
		unlock(8'h01);
		mwr(16'h0210, 8'h00);
		@(posedge clk);
		#1;
		chk(fl_prog, 1'b0, "program in guarded sector");
		cmd(FPU_CMD_PERASE);
		chk(fl_page_erase, 1'b0, "erase in guarded sector");
		wr(FPU_ADDR_CMD, 8'h00);
		size_8k <= 1'b0;
		unlock(8'h01);
		mwr(16'h0210, 8'h00);
		@(posedge clk);
		#1;
		chk(fl_prog, 1'b1, "small part page 1 guarded");
		wait_idle(n);
		wr(FPU_ADDR_CMD, 8'h00);
		size_8k <= 1'b1;
	endtask

	task automatic t_wp();
		@(posedge clk);
		write_protect_option <= 1'b0;
		unlock(8'h04);
		cmd(FPU_CMD_PERASE);
		chk(fl_page_erase, 1'b0, "erase while protected");
		wr(FPU_ADDR_CMD, 8'h00);
		write_protect_option <= 1'b1;
	endtask

	task automatic t_rdp();
		@(posedge clk);
		dbg_mode <= 1'b1;
		read_protect_option <= 1'b1;
		mrd(16'h0010);
		chk(rd_q, 8'h00, "code visible to debugger");
		mrd(16'h0001);
		chk(rd_q, pat(13'h0001), "option byte hidden");
		read_protect_option <= 1'b0;
		mrd(16'h0010);
		chk(rd_q, pat(13'h0010), "debug read");
		dbg_mode <= 1'b0;
	endtask

	task automatic t_info();
		mrd(16'hFE00);
		chk(rd_q, 8'hC3, "info read");
		unlock(8'h0F);
		mwr(16'hFE00, 8'h00);
		@(posedge clk);
		#1;
		chk(fl_prog, 1'b0, "info programmed");
		wr(FPU_ADDR_CMD, 8'h00);
	endtask

	task automatic t_mass();
		int n;
		unlock(8'h04);
		cmd(FPU_CMD_MERASE);
		chk(fl_mass_erase, 1'b0, "user mass erase");
		wr(FPU_ADDR_CMD, 8'h00);
		dbg_mode <= 1'b1;
		unlock(8'h00);
		cmd(FPU_CMD_MERASE);
		chk(fl_mass_erase, 1'b1, "debug mass erase");
		wait_idle(n);
		@(posedge clk);
		dbg_mode <= 1'b0;
		mrd(16'h0605);
		chk(rd_q, 8'hFF, "not blank");
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		{sys_rst, size_8k, write_protect_option} = 3'b111;
		{read_protect_option, dbg_mode, reg_wr, reg_rd, mem_wr, mem_rd} = 6'h00;
		{reg_addr, reg_wdata, mem_addr, mem_wdata} = 44'h0;
		err_count = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		wr(FPU_ADDR_FRQ_HI, 8'h03);
		wr(FPU_ADDR_FRQ_LO, 8'hE8);
		t_erase();
		t_mismatch();
		t_prog(16'h03E8, 8'h0F, pat(13'h0605));
		t_prog(16'h07D0, 8'hF0, 8'h0F & pat(13'h0605));
		t_guard();
		t_wp();
		t_rdp();
		t_info();
		t_mass();
		report_and_stop();
	end
endmodule
